// file: rtl/wake_frame_detector.sv
// Purpose: Receive wake frame detector with APB register access
// Assumes: One received byte per cycle, first byte is the delimiter
// Notes:   Status flags clear on read, a new event wins
// Operation
// - Release bit clears held wake in level mode
// - Pulse length 8/16/32/64 fast clock ticks
// - Bit 8 picks level, else pulse mode
// - Bit 7 enables detection and CRC checking
// - Bit 5 enables magic password check
// - Bit 4 wakes on matching unicast frame
// - Bit 2 wakes on broadcast, resets one
// - Bit 1 wakes on pattern match
// - Bit 0 wakes on magic frame
// - Status 7 flags bad delimiter, clears on read
// - Status 6 flags bad CRC, clears on read
// - Status 5 flags wrong magic password
// - Status 4 flags valid unicast frame
// - Status 2 flags valid broadcast frame
// - Status 1 flags valid pattern frame
// - Status 0 flags valid magic frame
// - Destination match value in three registers
// - Password held in three registers, reset zero
// - Pattern bytes 0 and 1, reset zero
module wake_frame_detector
  import wake_frame_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic        rx_first,
  input  wire logic        rx_last,
  input  wire logic [7:0]  rx_data,
  output logic             rx_sfd_seen,
  output logic             wake_output
);

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic [6:0] pulse_cycles(input logic [1:0] sel);
    int ticks;
    ticks = WAKE_TICKS_MIN << sel;
    return 7'((ticks * WAKE_TICK_PS + PCLK_PS - 1) / PCLK_PS);
  endfunction : pulse_cycles

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [15:0]  config_reg;
  logic [7:0]   status;
  logic [47:0]  match_addr;
  logic [47:0]  magic_pass;
  logic [15:0]  pattern;
  logic [1:0]   pattern_byte_exclude;
  logic [9:0]   index;
  logic         mapped;
  logic         setup;
  logic         access_wr;
  logic         status_rd;
  logic         release_pulse;
  logic [31:0]  next_rdata;
  logic [7:0]   set_flags;
  logic         wake_trigger;

  assign index     = paddr[11:2];
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite && !pslverr;
  assign status_rd = psel && penable && !pwrite && !pslverr && index == IDX_STATUS;
  assign pready    = 1'b1;
  assign release_pulse = access_wr && index == IDX_CONFIG && pstrb[1]
                         && pwdata[CFG_RELEASE];

  always_comb begin
    mapped     = paddr[1:0] == 2'b00;
    next_rdata = 32'h00000000;
    case (index)
      IDX_CONFIG:    next_rdata[15:0] = config_reg;
      IDX_STATUS:    next_rdata[7:0]  = status;
      IDX_ADDR_LOW:  next_rdata[15:0] = match_addr[15:0];
      IDX_ADDR_MID:  next_rdata[15:0] = match_addr[31:16];
      IDX_ADDR_HIGH: next_rdata[15:0] = match_addr[47:32];
      IDX_PASS_LOW:  next_rdata[15:0] = magic_pass[15:0];
      IDX_PASS_MID:  next_rdata[15:0] = magic_pass[31:16];
      IDX_PASS_HIGH: next_rdata[15:0] = magic_pass[47:32];
      IDX_PATTERN:   next_rdata[15:0] = pattern;
      IDX_PAT_MASK:  next_rdata[1:0]  = pattern_byte_exclude;
      default:       mapped = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg           <= CONFIG_RESET;
      match_addr           <= 48'h000000000000;
      magic_pass           <= 48'h000000000000;
      pattern              <= 16'h0000;
      pattern_byte_exclude <= 2'b00;
    end else if (access_wr) begin
      case (index)
        IDX_CONFIG:    config_reg <= merge(config_reg, pwdata, pstrb) & CONFIG_RW_MASK;
        IDX_ADDR_LOW:  match_addr[15:0]  <= merge(match_addr[15:0], pwdata, pstrb);
        IDX_ADDR_MID:  match_addr[31:16] <= merge(match_addr[31:16], pwdata, pstrb);
        IDX_ADDR_HIGH: match_addr[47:32] <= merge(match_addr[47:32], pwdata, pstrb);
        IDX_PASS_LOW:  magic_pass[15:0]  <= merge(magic_pass[15:0], pwdata, pstrb);
        IDX_PASS_MID:  magic_pass[31:16] <= merge(magic_pass[31:16], pwdata, pstrb);
        IDX_PASS_HIGH: magic_pass[47:32] <= merge(magic_pass[47:32], pwdata, pstrb);
        IDX_PATTERN:   pattern <= merge(pattern, pwdata, pstrb);
        IDX_PAT_MASK:  if (pstrb[0]) pattern_byte_exclude <= pwdata[1:0];
        default:       config_reg <= config_reg;
      endcase
    end
  end

  // Only the bits returned by the read are cleared; a new set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 8'h00;
    end else begin
      status <= (status & ~(status_rd ? prdata[7:0] : 8'h00)) | set_flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame tracking
  logic         ext_en;
  logic         in_frame;
  logic         sfd_ok;
  logic [7:0]   pos;
  logic [31:0]  crc;
  logic [31:0]  next_crc;
  logic         da_match;
  logic         da_bcast;
  logic         pat_ok;
  logic [7:0]   da_byte;
  logic         frame_end;
  logic         crc_good;

  assign ext_en    = config_reg[CFG_EXT_EN];
  assign next_crc  = crc_step(rx_first ? CRC_INIT : crc, rx_data);
  assign frame_end = rx_valid && rx_last && in_frame && sfd_ok;
  assign crc_good  = next_crc == CRC_RESIDUE;
  assign da_byte   = 8'(match_addr >> {pos[2:0] - 3'h1, 3'b000});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame    <= 1'b0;
      sfd_ok      <= 1'b0;
      pos         <= 8'h00;
      crc         <= CRC_INIT;
      da_match    <= 1'b0;
      da_bcast    <= 1'b0;
      pat_ok      <= 1'b0;
      rx_sfd_seen <= 1'b0;
    end else begin
      rx_sfd_seen <= rx_valid && rx_first && ext_en && rx_data == SFD_BYTE;
      if (rx_valid && rx_first) begin
        in_frame <= !rx_last;
        sfd_ok   <= rx_data == SFD_BYTE;
        pos      <= 8'h01;
        crc      <= CRC_INIT;
        da_match <= 1'b1;
        da_bcast <= 1'b1;
        pat_ok   <= 1'b1;
      end else if (rx_valid && in_frame) begin
        in_frame <= !rx_last;
        crc      <= next_crc;
        if (pos != 8'hff) pos <= pos + 8'h01;
        if (pos >= 8'h01 && pos <= 8'h06) begin
          if (rx_data != da_byte) da_match <= 1'b0;
          if (rx_data != SYNC_BYTE) da_bcast <= 1'b0;
        end
        if (pos == 8'h01 && !pattern_byte_exclude[0] && rx_data != pattern[7:0])
          pat_ok <= 1'b0;
        if (pos == 8'h02 && !pattern_byte_exclude[1] && rx_data != pattern[15:8])
          pat_ok <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Magic frame search
  magic_state_t mstate;
  logic [2:0]   ff_run;
  logic [6:0]   mpos;
  logic         pass_bad;
  logic [7:0]   mag_addr_byte;
  logic [7:0]   mag_pass_byte;
  logic [2:0]   mbyte;

  assign mbyte         = 3'(mpos % 7'd6);
  assign mag_addr_byte = 8'(match_addr >> {mbyte, 3'b000});
  assign mag_pass_byte = 8'(magic_pass >> {mbyte, 3'b000});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate   <= M_SYNC;
      ff_run   <= 3'h0;
      mpos     <= 7'h00;
      pass_bad <= 1'b0;
    end else if (rx_valid && rx_first) begin
      mstate   <= M_SYNC;
      ff_run   <= 3'h0;
      mpos     <= 7'h00;
      pass_bad <= 1'b0;
    end else if (rx_valid && in_frame && pos >= PAYLOAD_START) begin
      case (mstate)
        M_SYNC: begin
          ff_run <= rx_data == SYNC_BYTE ? ff_run + 3'h1 : 3'h0;
          if (rx_data == SYNC_BYTE && ff_run == SYNC_COUNT - 3'h1) begin
            mstate <= M_ADDR;
            mpos   <= 7'h00;
          end
        end
        M_ADDR: begin
          if (rx_data == mag_addr_byte) begin
            mpos <= mpos + 7'h01;
            if (mpos == ADDR_REPEAT_BYTES - 7'h01) begin
              mstate <= config_reg[CFG_PASS_EN] ? M_PASS : M_DONE;
              mpos   <= 7'h00;
            end
          end else if (!(mpos == 7'h00 && rx_data == SYNC_BYTE)) begin
            mstate <= M_SYNC;
            ff_run <= rx_data == SYNC_BYTE ? 3'h1 : 3'h0;
          end
        end
        M_PASS: begin
          if (rx_data != mag_pass_byte) pass_bad <= 1'b1;
          mpos <= mpos + 7'h01;
          if (mpos == 7'h05) mstate <= M_DONE;
        end
        M_DONE:  mstate <= M_DONE;
        default: mstate <= M_SYNC;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events and wake output
  logic       good;
  logic       magic_hit;
  logic [6:0] pulse_left;

  assign good      = frame_end && crc_good;
  assign magic_hit = mstate == M_DONE && !pass_bad;

  always_comb begin
    set_flags = 8'h00;
    if (ext_en) begin
      set_flags[ST_DELIM_ERR] = rx_valid && rx_first && rx_data != SFD_BYTE;
      set_flags[ST_BAD_CRC] = frame_end && !crc_good;
      set_flags[ST_ATTACK]  = good && mstate == M_DONE && pass_bad;
      set_flags[ST_UCAST]   = good && da_match;
      set_flags[ST_BCAST]   = good && da_bcast;
      set_flags[ST_PATTERN] = good && pat_ok;
      set_flags[ST_MAGIC]   = good && magic_hit;
    end
  end

  assign wake_trigger = (set_flags[ST_UCAST] && config_reg[CFG_UCAST_EN])
                      || (set_flags[ST_BCAST] && config_reg[CFG_BCAST_EN])
                      || (set_flags[ST_PATTERN] && config_reg[CFG_PAT_EN])
                      || (set_flags[ST_MAGIC] && config_reg[CFG_MAGIC_EN]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_output <= 1'b0;
      pulse_left  <= 7'h00;
    end else if (config_reg[CFG_LEVEL]) begin
      pulse_left <= 7'h00;
      if (wake_trigger) wake_output <= 1'b1;
      else if (release_pulse) wake_output <= 1'b0;
    end else if (wake_trigger) begin
      wake_output <= 1'b1;
      pulse_left  <= pulse_cycles(config_reg[10:9]) - 7'h01;
    end else if (pulse_left != 7'h00) begin
      pulse_left <= pulse_left - 7'h01;
    end else begin
      wake_output <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [6:0] high_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) high_run <= 7'h00;
    else if (!wake_output) high_run <= 7'h00;
    else if (high_run != 7'h7f) high_run <= high_run + 7'h01;
  end

  pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    !config_reg[CFG_LEVEL] && $fell(wake_output) && $stable(config_reg)
      |-> high_run >= pulse_cycles(config_reg[10:9]))
    else $error("wake pulse too short");

  release_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    config_reg[CFG_LEVEL] && release_pulse && !wake_trigger |=> !wake_output)
    else $error("release did not clear wake");

  level_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    config_reg[CFG_LEVEL] && wake_output && !release_pulse
      |=> wake_output)
    else $error("level wake dropped");

  sfd_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_en && rx_valid && rx_first && rx_data != SFD_BYTE |=> status[ST_DELIM_ERR])
    else $error("delimiter error not flagged");

  crc_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_en && frame_end && !crc_good |-> !wake_trigger ##1 status[ST_BAD_CRC])
    else $error("bad crc not flagged");

  ext_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_en |-> set_flags == 8'h00 && !wake_trigger)
    else $error("events while features off");

  bcast_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_flags[ST_BCAST] && config_reg[CFG_BCAST_EN] |=> wake_output && status[ST_BCAST])
    else $error("broadcast did not wake");

  read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_rd && prdata[ST_UCAST] && !set_flags[ST_UCAST] |=> !status[ST_UCAST])
    else $error("status not cleared by read");

  ucast_a: assert property (@(posedge pclk) disable iff (!presetn)
    good && !da_match && !da_bcast && !pat_ok && !magic_hit |-> !wake_trigger)
    else $error("wake without match");

  pulse_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    !config_reg[CFG_LEVEL] && wake_output && pulse_left == 7'h00 && !wake_trigger
      |=> !wake_output)
    else $error("wake pulse too long");

  sfd_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_en && rx_valid && rx_first && rx_data == SFD_BYTE |=> rx_sfd_seen)
    else $error("delimiter indication missing");

  wake_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_trigger |=> wake_output)
    else $error("wake not raised on event");

endmodule : wake_frame_detector

// file: rtl/wake_frame_pkg.sv
// Purpose: Constants for the receive wake frame detector
// Assumes: Register indices times four give APB byte addresses
// Notes:   Frame bytes arrive one per pclk cycle
package wake_frame_pkg;
  // Register indices
  localparam logic [9:0]  IDX_CONFIG     = 10'h134;
  localparam logic [9:0]  IDX_STATUS     = 10'h135;
  localparam logic [9:0]  IDX_ADDR_LOW   = 10'h136;
  localparam logic [9:0]  IDX_ADDR_MID   = 10'h137;
  localparam logic [9:0]  IDX_ADDR_HIGH  = 10'h138;
  localparam logic [9:0]  IDX_PASS_LOW   = 10'h139;
  localparam logic [9:0]  IDX_PASS_MID   = 10'h13a;
  localparam logic [9:0]  IDX_PASS_HIGH  = 10'h13b;
  localparam logic [9:0]  IDX_PATTERN    = 10'h13c;
  localparam logic [9:0]  IDX_PAT_MASK   = 10'h150;
  // Config reset value and writable bit mask
  localparam logic [15:0] CONFIG_RESET   = 16'h0004;
  localparam logic [15:0] CONFIG_RW_MASK = 16'h07b7;
  // Config field positions
  localparam int          CFG_RELEASE    = 11;
  localparam int          CFG_STRETCH_LO = 9;
  localparam int          CFG_LEVEL      = 8;
  localparam int          CFG_EXT_EN     = 7;
  localparam int          CFG_PASS_EN    = 5;
  localparam int          CFG_UCAST_EN   = 4;
  localparam int          CFG_BCAST_EN   = 2;
  localparam int          CFG_PAT_EN     = 1;
  localparam int          CFG_MAGIC_EN   = 0;
  // Status field positions
  localparam int          ST_DELIM_ERR   = 7;
  localparam int          ST_BAD_CRC     = 6;
  localparam int          ST_ATTACK      = 5;
  localparam int          ST_UCAST       = 4;
  localparam int          ST_BCAST       = 2;
  localparam int          ST_PATTERN     = 1;
  localparam int          ST_MAGIC       = 0;
  // Frame layout and constants
  localparam logic [7:0]  SFD_BYTE       = 8'h5d;
  localparam logic [7:0]  SYNC_BYTE      = 8'hff;
  localparam logic [7:0]  PAYLOAD_START  = 8'h0f;
  localparam logic [2:0]  SYNC_COUNT     = 3'h6;
  localparam logic [6:0]  ADDR_REPEAT_BYTES = 7'h60;
  localparam logic [31:0] CRC_INIT       = 32'hffffffff;
  localparam logic [31:0] CRC_POLY       = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE    = 32'hdebb20e3;
  // Timing of the wake pulse
  localparam int          WAKE_TICK_PS   = 8000;
  localparam int          PCLK_PS        = 50000;
  localparam int          WAKE_TICKS_MIN = 8;
  typedef enum logic [1:0] {M_SYNC, M_ADDR, M_PASS, M_DONE} magic_state_t;
endpackage : wake_frame_pkg

// file: sim/frame_source.sv
// Purpose: Line-side receive path model feeding frames byte by byte
// Assumes: One byte per pclk cycle, optional idle gap after each byte
// Notes:   Data line shows the inverted last byte while idle
module frame_source
  import wake_frame_pkg::*;
(
  input  wire logic       pclk,
  output logic            rx_valid,
  output logic            rx_first,
  output logic            rx_last,
  output logic      [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last  = 1'b0;
    rx_data  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_byte

  // Kind 0 plain, 1 magic, 2 magic with password
  task automatic send(input logic [7:0] sfd, input logic [47:0] da, input logic [1:0] kind,
                      input logic [47:0] maddr, input logic [47:0] pw, input logic crc_bad,
                      input logic slow);
    logic [7:0]  fb[$];
    logic [31:0] c;
    for (int k = 0; k < 6; k++) fb.push_back(da[8*k+:8]);
    for (int k = 0; k < 6; k++) fb.push_back(8'h20 + 8'(k));
    fb.push_back(8'h08);
    fb.push_back(8'h00);
    if (kind == 2'd0) begin
      for (int k = 0; k < 4; k++) fb.push_back(8'ha0 + 8'(k));
    end else begin
      for (int k = 0; k < 6; k++) fb.push_back(8'hff);
      for (int k = 0; k < 96; k++) fb.push_back(maddr[8*(k%6)+:8]);
      if (kind == 2'd2) for (int k = 0; k < 6; k++) fb.push_back(pw[8*k+:8]);
    end
    c = CRC_INIT;
    foreach (fb[i]) c = crc_byte(c, fb[i]);
    c = ~c ^ {31'h0, crc_bad};
    for (int k = 0; k < 4; k++) fb.push_back(c[8*k+:8]);
    fb.push_front(sfd);
    foreach (fb[i]) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_first <= (i == 0);
      rx_last  <= (i == fb.size() - 1);
      rx_data  <= fb[i];
      if (slow && i < fb.size() - 1) begin
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_data  <= ~fb[i];
      end
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~fb[fb.size()-1];
  endtask : send
endmodule : frame_source

// file: sim/tb_wake_frame_detector.sv
// Purpose: Self-checking bench for the wake frame detector
// Assumes: Zero wait state APB slave, frames from frame_source
// Notes:   Byte address is register index times four
module tb_wake_frame_detector
  import wake_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [47:0] MA = 48'hab89_6745_2302;
  localparam logic [47:0] PW = 48'h0f0e_0d0c_0b0a;
  localparam logic [47:0] OD = 48'h5544_3322_110c;
  localparam logic [47:0] BC = 48'hffff_ffff_ffff;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        rx_valid, rx_first, rx_last, rx_sfd_seen, wake_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  rx_data;
  logic [31:0] wid [4];
  int          bad_count, n_tests, w;
  int          sfd_n = 0;

  wake_frame_detector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_last(rx_last), .rx_data(rx_data), .rx_sfd_seen(rx_sfd_seen),
    .wake_output(wake_output));

  frame_source i_src (.pclk(pclk), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_last(rx_last), .rx_data(rx_data));

  // Counts delimiter indication pulses
  always @(posedge pclk) if (rx_sfd_seen === 1'b1) sfd_n <= sfd_n + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      print_verdict;
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task rdchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0);
    chk(name, exp, rd);
  endtask : rdchk

  task wake_is(input logic exp);
    #1;
    chk("wake_output", {31'h0, exp}, {31'h0, wake_output});
  endtask : wake_is

  task fr(input logic [7:0] sfd, input logic [47:0] da, input logic [1:0] kind,
          input logic [47:0] pw, input logic bad, input logic slow);
    i_src.send(sfd, da, kind, MA, pw, bad, slow);
  endtask : fr

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    print_verdict;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    bad_count = 0;
    n_tests = 0;
    wid = '{32'd2, 32'd3, 32'd6, 32'd11};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("config", IDX_CONFIG, 32'h0004);
    for (int i = 0; i < 8; i++) rdchk("reset_value", IDX_STATUS + 10'(i), 32'h0);
    apb(1'b0, 10'h200, 16'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_ADDR_LOW + 10'(i), MA[16*i+:16]);
      apb(1'b1, IDX_PASS_LOW + 10'(i), PW[16*i+:16]);
    end
    rdchk("addr_high", IDX_ADDR_HIGH, {16'h0, MA[47:32]});
    rdchk("pass_low", IDX_PASS_LOW, {16'h0, PW[15:0]});
    // Extended features off
    apb(1'b1, IDX_CONFIG, 16'h0014);
    w = sfd_n;
    fr(SFD_BYTE, MA, 2'd0, 48'h0, 1'b0, 1'b0);
    wake_is(1'b0);
    chk("sfd_pulses", 32'h0, 32'(sfd_n - w));
    rdchk("status", IDX_STATUS, 32'h0);
    // Level mode unicast with byte gaps
    apb(1'b1, IDX_CONFIG, 16'h0190);
    rdchk("config", IDX_CONFIG, 32'h0190);
    w = sfd_n;
    fr(SFD_BYTE, MA, 2'd0, 48'h0, 1'b0, 1'b1);
    wake_is(1'b1);
    chk("sfd_pulses", 32'h1, 32'(sfd_n - w));
    rdchk("status", IDX_STATUS, 32'h10);
    rdchk("status", IDX_STATUS, 32'h0);
    wake_is(1'b1);
    apb(1'b1, IDX_CONFIG, 16'h0990);
    rdchk("config", IDX_CONFIG, 32'h0190);
    wake_is(1'b0);
    // Broadcast disabled, then pulse widths
    apb(1'b1, IDX_CONFIG, 16'h0080);
    fr(SFD_BYTE, BC, 2'd0, 48'h0, 1'b0, 1'b0);
    wake_is(1'b0);
    rdchk("status", IDX_STATUS, 32'h04);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, IDX_CONFIG, 16'h0084 | 16'(s << 9));
      fr(SFD_BYTE, BC, 2'd0, 48'h0, 1'b0, 1'b0);
      #1;
      w = 0;
      while (wake_output === 1'b1 && w < 100) begin
        @(posedge pclk);
        #1;
        w++;
      end
      chk("pulse_cycles", wid[s], w);
      rdchk("status", IDX_STATUS, 32'h04);
    end
    // Bad CRC and bad delimiter
    apb(1'b1, IDX_CONFIG, 16'h0184);
    fr(SFD_BYTE, BC, 2'd0, 48'h0, 1'b1, 1'b0);
    wake_is(1'b0);
    rdchk("status", IDX_STATUS, 32'h40);
    fr(8'h55, BC, 2'd0, 48'h0, 1'b0, 1'b0);
    wake_is(1'b0);
    rdchk("status", IDX_STATUS, 32'h80);
    // Magic frames, password off then on
    apb(1'b1, IDX_CONFIG, 16'h0181);
    fr(SFD_BYTE, OD, 2'd1, 48'h0, 1'b0, 1'b0);
    wake_is(1'b1);
    rdchk("status", IDX_STATUS, 32'h01);
    apb(1'b1, IDX_CONFIG, 16'h0981);
    apb(1'b1, IDX_CONFIG, 16'h01a1);
    fr(SFD_BYTE, OD, 2'd2, PW ^ 48'h1, 1'b0, 1'b1);
    wake_is(1'b0);
    rdchk("status", IDX_STATUS, 32'h20);
    fr(SFD_BYTE, OD, 2'd2, PW, 1'b0, 1'b0);
    wake_is(1'b1);
    rdchk("status", IDX_STATUS, 32'h01);
    apb(1'b1, IDX_CONFIG, 16'h09a1);
    // Pattern match and byte exclusion
    apb(1'b1, IDX_PATTERN, OD[15:0]);
    rdchk("pattern", IDX_PATTERN, {16'h0, OD[15:0]});
    apb(1'b1, IDX_CONFIG, 16'h0182);
    fr(SFD_BYTE, OD, 2'd0, 48'h0, 1'b0, 1'b0);
    wake_is(1'b1);
    rdchk("status", IDX_STATUS, 32'h02);
    apb(1'b1, IDX_CONFIG, 16'h0982);
    fr(SFD_BYTE, 48'h5544_3322_0908, 2'd0, 48'h0, 1'b0, 1'b0);
    rdchk("status", IDX_STATUS, 32'h0);
    apb(1'b1, IDX_PAT_MASK, 16'h0003);
    fr(SFD_BYTE, 48'h5544_3322_0908, 2'd0, 48'h0, 1'b0, 1'b0);
    rdchk("status", IDX_STATUS, 32'h02);
    print_verdict;
  end
endmodule : tb_wake_frame_detector
